// ===== inc/asp_consts.vh
// Purpose: Shared constants of the asynchronous serial port register block.
// Assumes: Register indices sit at byte address four times the index.
// Notes: Included by bare name.
`ifndef ASP_CONSTS_VH
`define ASP_CONSTS_VH
`define ASP_IDX_RXCS 16'hfed0
`define ASP_IDX_TXCF 16'hfed1
`define ASP_IDX_BAUD 16'hfed2
`define ASP_IDX_TXHB 16'hfed3
`define ASP_IDX_RXHB 16'hfed4
`define ASP_RST_BYTE 8'h00
`define ASP_RXCS_BSEL 7
`define ASP_RXCS_SDET 6
`define ASP_RXCS_RUN 5
`define ASP_RXCS_SERR 4
`define ASP_RXCS_SPARE 3
`define ASP_RXCS_NINTH 2
`define ASP_RXCS_END 1
`define ASP_RXCS_IE 0
`define ASP_TXCF_RUN 7
`define ASP_TXCF_LEN9 6
`define ASP_TXCF_OE 5
`define ASP_TXCF_PP 4
`define ASP_TXCF_LEN7 3
`define ASP_TXCF_NINTH 2
`define ASP_TXCF_EMPTY 1
`define ASP_TXCF_IE 0
`define ASP_BAUD_STEP 14'd3
`define ASP_BAUD_MUL_HI 5
`define ASP_BAUD_MUL_LO 3
`define ASP_RESP_OKAY 2'b00
`define ASP_RESP_SLVERR 2'b10
`endif

// ===== rtl/asp_top.v
// Purpose: Full-duplex asynchronous serial port with AXI4-Lite register access.
// Assumes: One clock cycle is one CPU cycle; rx_pin is synchronous to clk.
// Notes: Frame timing uses a thirds accumulator so bit periods average n+1 times 8/3 or 32/3 cycles.
// Notes on behaviour
// RULE1 - Bit period (n+1)*32/3 or (n+1)*8/3 cycles.
// RULE2 - Falling rx edge starts reception when detection enabled.
// RULE3 - Enabling detection with rx low starts immediately.
// RULE4 - Running flag self-clears; software clear aborts reception.
// RULE5 - Abort sets end, copies partial data, flags.
// RULE6 - Low stop bit sets sticky stop error.
// RULE7 - Nine-bit length stores ninth received bit.
// RULE8 - Reception end sets end flag, fills buffer.
// RULE9 - Starts ignored while a reception is running.
// RULE10 - Receive interrupt when enable and end flag.
// RULE11 - Run bit starts frame; clearing aborts immediately.
// RULE12 - Continuous transmit leaves one-cycle gap between frames.
// RULE13 - Control write at frame end blocks restart.
// RULE14 - Length codes give nine, eight, seven bits.
// RULE15 - Output enable gates data onto transmit pin.
// RULE16 - Drive type select: push-pull or open drain.
// RULE17 - Nine-bit frames send the stored ninth bit.
// RULE18 - Start copies buffer; empty flag next cycle.
// RULE19 - Cleared empty flag restarts transmit at frame end.
// RULE20 - Transmit interrupt when enable and empty flag.
// RULE21 - Baud counter resets while both directions idle.
// RULE22 - Seven-bit receive writes zero buffer MSB.
// RULE23 - Seven to nine data bits, LSB first.
// RULE24 - One stop bit, two when continuous.
// RULE25 - Each received bit sampled near its middle.
// RULE26 - Low start, data, high stops, one period each.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "asp_consts.vh"
module asp_top #(
  parameter AW = 18
) (
  input wire clk,
  input wire srst,
  input wire [AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire rx_pin,
  output reg tx_pin_o,
  output reg tx_pin_oe_n,
  output wire rx_irq,
  output wire tx_irq
);
  localparam TX_IDLE = 3'b001;
  localparam TX_SEND = 3'b010;
  localparam TX_EMPT = 3'b100;

  reg [7:0] rxcs_r;
  reg [7:0] txcf_r;
  reg [7:0] baud_r;
  reg [7:0] txhb_r;
  reg [7:0] rxhb_r;
  reg aw_have_r;
  reg w_have_r;
  reg [AW-1:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg w_strb0_r;
  reg [13:0] tx_acc_r;
  reg [13:0] rx_acc_r;
  reg rx_prev_r;
  reg [10:0] rx_sh_r;
  reg [3:0] rx_cnt_r;
  reg rx_last_r;
  reg rx_plast_r;
  reg [2:0] tx_st_r;
  reg [10:0] tx_sh_r;
  reg [3:0] tx_cnt_r;
  reg tx_extra_r;

  // Write channel: address and data may arrive in either order.
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  assign s_axi_awready = ~aw_have_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_have_r & ~s_axi_bvalid;
  wire do_wr = (aw_have_r | aw_take) & (w_have_r | w_take) & ~s_axi_bvalid;
  wire [AW-1:0] wa = aw_have_r ? aw_addr_r : s_axi_awaddr;
  wire [31:0] wd = w_have_r ? w_data_r : s_axi_wdata;
  wire ws = w_have_r ? w_strb0_r : s_axi_wstrb[0];
  wire [15:0] widx = wa[17:2];
  wire wr_ok = do_wr & (wa[1:0] == 2'b00) & (widx >= `ASP_IDX_RXCS) & (widx <= `ASP_IDX_RXHB);
  wire wr_en = wr_ok & ws;
  wire wr_rxcs = wr_en & (widx == `ASP_IDX_RXCS);
  wire wr_txcf = wr_en & (widx == `ASP_IDX_TXCF);
  wire wr_baud = wr_en & (widx == `ASP_IDX_BAUD);
  wire wr_txhb = wr_en & (widx == `ASP_IDX_TXHB);
  wire wr_rxhb = wr_en & (widx == `ASP_IDX_RXHB);

  always @(posedge clk)
  begin
    if (srst)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= {AW{1'b0}};
      w_data_r <= 32'h0;
      w_strb0_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ASP_RESP_OKAY;
    end
    else
    begin
      if (aw_take)
        aw_addr_r <= s_axi_awaddr;
      if (w_take)
      begin
        w_data_r <= s_axi_wdata;
        w_strb0_r <= s_axi_wstrb[0];
      end
      if (do_wr)
      begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `ASP_RESP_OKAY : `ASP_RESP_SLVERR;
      end
      else
      begin
        if (aw_take)
          aw_have_r <= 1'b1;
        if (w_take)
          w_have_r <= 1'b1;
        if (s_axi_bvalid & s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel answers one cycle after the address is taken.
  assign s_axi_arready = ~s_axi_rvalid;
  wire [15:0] ridx = s_axi_araddr[17:2];
  always @(posedge clk)
  begin
    if (srst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `ASP_RESP_OKAY;
    end
    else if (s_axi_arvalid & s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `ASP_RESP_OKAY;
      s_axi_rdata <= 32'h0;
      if (s_axi_araddr[1:0] != 2'b00)
        s_axi_rresp <= `ASP_RESP_SLVERR;
      else if (ridx == `ASP_IDX_RXCS)
        s_axi_rdata <= {24'h0, rxcs_r};
      else if (ridx == `ASP_IDX_TXCF)
        s_axi_rdata <= {24'h0, txcf_r};
      else if (ridx == `ASP_IDX_BAUD)
        s_axi_rdata <= {24'h0, baud_r};
      else if (ridx == `ASP_IDX_TXHB)
        s_axi_rdata <= {24'h0, txhb_r};
      else if (ridx == `ASP_IDX_RXHB)
        s_axi_rdata <= {24'h0, rxhb_r};
      else
        s_axi_rresp <= `ASP_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Baud limit in thirds of a cycle; the accumulator gains three per cycle.
  wire [8:0] n1 = {1'b0, baud_r} + 9'h1;
  wire [13:0] lim = rxcs_r[`ASP_RXCS_BSEL] ? {n1, 5'h0} : {2'h0, n1, 3'h0}; // [RULE1]
  wire len9 = txcf_r[`ASP_TXCF_LEN9] & ~txcf_r[`ASP_TXCF_LEN7]; // [RULE14]
  wire len7 = txcf_r[`ASP_TXCF_LEN7] & ~txcf_r[`ASP_TXCF_LEN9]; // [RULE14]
  wire [3:0] dlen = len9 ? 4'd9 : (len7 ? 4'd7 : 4'd8); // [RULE23]
  wire [3:0] flen = dlen + 4'd2;

  wire rx_run = rxcs_r[`ASP_RXCS_RUN];
  wire tx_run = txcf_r[`ASP_TXCF_RUN];
  wire [13:0] tx_acc_add = tx_acc_r + `ASP_BAUD_STEP;
  wire tx_tick = tx_acc_add >= lim;
  always @(posedge clk)
  begin
    if (srst)
      tx_acc_r <= 14'h0;
    else if ((~rx_run & ~tx_run) | (tx_st_r == TX_IDLE))
      tx_acc_r <= 14'h0; // [RULE21] [RULE26]
    else if (tx_tick)
      tx_acc_r <= tx_acc_add - lim; // [RULE1]
    else
      tx_acc_r <= tx_acc_add;
  end

  // Receive engine.
  wire [13:0] rx_acc_add = rx_acc_r + `ASP_BAUD_STEP;
  wire rx_tick = rx_run & (rx_acc_add >= lim);
  wire [10:0] rx_sh_nxt = {rx_pin, rx_sh_r[10:1]};
  wire [3:0] rx_cnt_nxt = rx_cnt_r + 4'd1;
  wire rx_done = rx_tick & (rx_cnt_nxt == flen);
  wire rx_abort = wr_rxcs & ~wd[`ASP_RXCS_RUN] & rx_run & ~rx_done; // [RULE4]
  wire [10:0] rx_src = rx_done ? rx_sh_nxt : rx_sh_r;
  wire [7:0] rx_data = len9 ? rx_src[8:1] : (len7 ? {1'b0, rx_src[9:3]} : rx_src[9:2]); // [RULE22]
  wire sdet_rise = wr_rxcs & wd[`ASP_RXCS_SDET] & ~rxcs_r[`ASP_RXCS_SDET];
  wire rx_fall = rx_prev_r & ~rx_pin;
  wire rx_start = ~rx_run & ((rxcs_r[`ASP_RXCS_SDET] & rx_fall) | (sdet_rise & ~rx_pin)); // [RULE2] [RULE3] [RULE9]
  wire rx_fin = rx_done | rx_abort;

  always @(posedge clk)
  begin
    if (srst)
    begin
      rx_prev_r <= 1'b1;
      rx_acc_r <= 14'h0;
      rx_sh_r <= 11'h0;
      rx_cnt_r <= 4'h0;
      rx_last_r <= 1'b1;
      rx_plast_r <= 1'b1;
    end
    else
    begin
      rx_prev_r <= rx_pin;
      if (rx_start)
      begin
        rx_acc_r <= {1'b0, lim[13:1]}; // [RULE25]
        rx_cnt_r <= 4'h0;
        rx_sh_r <= 11'h0;
        rx_last_r <= 1'b1;
        rx_plast_r <= 1'b1;
      end
      else if (rx_tick)
      begin
        rx_acc_r <= rx_acc_add - lim; // [RULE25]
        rx_sh_r <= rx_sh_nxt; // [RULE23]
        rx_cnt_r <= rx_cnt_nxt;
        rx_last_r <= rx_pin;
        rx_plast_r <= rx_last_r;
      end
      else if (rx_run)
        rx_acc_r <= rx_acc_add;
    end
  end

  // Receive-side control register; hardware set wins over software clear.
  always @(posedge clk)
  begin
    if (srst)
    begin
      rxcs_r <= `ASP_RST_BYTE;
      rxhb_r <= `ASP_RST_BYTE;
      baud_r <= `ASP_RST_BYTE;
    end
    else
    begin
      if (wr_baud)
        baud_r <= wd[7:0];
      if (wr_rxcs)
      begin
        rxcs_r[`ASP_RXCS_BSEL] <= wd[`ASP_RXCS_BSEL];
        rxcs_r[`ASP_RXCS_SDET] <= wd[`ASP_RXCS_SDET];
        rxcs_r[`ASP_RXCS_SERR] <= wd[`ASP_RXCS_SERR];
        rxcs_r[`ASP_RXCS_SPARE] <= wd[`ASP_RXCS_SPARE];
        rxcs_r[`ASP_RXCS_NINTH] <= wd[`ASP_RXCS_NINTH];
        rxcs_r[`ASP_RXCS_END] <= wd[`ASP_RXCS_END];
        rxcs_r[`ASP_RXCS_IE] <= wd[`ASP_RXCS_IE];
        rxcs_r[`ASP_RXCS_RUN] <= rx_run & wd[`ASP_RXCS_RUN]; // [RULE4]
      end
      if (wr_rxhb)
        rxhb_r <= wd[7:0];
      if (rx_start)
        rxcs_r[`ASP_RXCS_RUN] <= 1'b1; // [RULE2] [RULE3]
      if (rx_fin)
      begin
        rxcs_r[`ASP_RXCS_RUN] <= 1'b0; // [RULE4]
        rxcs_r[`ASP_RXCS_END] <= 1'b1; // [RULE8] [RULE5]
        rxhb_r <= rx_data; // [RULE8] [RULE5]
      end
      if (rx_done & ~rx_sh_nxt[10])
        rxcs_r[`ASP_RXCS_SERR] <= 1'b1; // [RULE6]
      if (rx_done & len9)
        rxcs_r[`ASP_RXCS_NINTH] <= rx_sh_nxt[9]; // [RULE7]
      if (rx_abort)
      begin
        if (~rx_last_r)
          rxcs_r[`ASP_RXCS_SERR] <= 1'b1; // [RULE5]
        rxcs_r[`ASP_RXCS_NINTH] <= rx_plast_r; // [RULE5]
      end
    end
  end

  // Transmit engine.
  wire [3:0] tx_cnt_nxt = tx_cnt_r + 4'd1;
  wire tx_empty = txcf_r[`ASP_TXCF_EMPTY];
  wire tx_sending = tx_st_r == TX_SEND;
  wire tx_abort = wr_txcf & ~wd[`ASP_TXCF_RUN] & tx_run & tx_sending; // [RULE11]
  wire tx_end = tx_sending & tx_tick & ~tx_abort &
    (((tx_cnt_nxt == flen) & (tx_empty | tx_extra_r)) | (tx_cnt_nxt == flen + 4'd1)); // [RULE24]
  wire tx_again = tx_end & tx_extra_r & ~wr_txcf; // [RULE12] [RULE13] [RULE19]
  wire tx_load = (tx_st_r == TX_IDLE) & tx_run;
  wire [10:0] tx_frame = len9 ? {1'b1, txcf_r[`ASP_TXCF_NINTH], txhb_r, 1'b0} : // [RULE17]
    (len7 ? {3'b111, txhb_r[6:0], 1'b0} : {2'b11, txhb_r, 1'b0}); // [RULE26]

  always @(posedge clk)
  begin
    if (srst)
    begin
      tx_st_r <= TX_IDLE;
      tx_sh_r <= 11'h7ff;
      tx_cnt_r <= 4'h0;
      tx_extra_r <= 1'b0;
    end
    else
    begin
      case (tx_st_r)
        TX_IDLE:
        begin
          if (tx_load)
          begin
            tx_sh_r <= tx_frame; // [RULE18]
            tx_cnt_r <= 4'h0;
            tx_extra_r <= 1'b0;
            tx_st_r <= TX_EMPT;
          end
        end
        TX_EMPT, TX_SEND:
        begin
          tx_st_r <= TX_SEND;
          if (tx_abort | ~tx_run | tx_end)
          begin
            tx_st_r <= TX_IDLE; // [RULE11] [RULE12]
            tx_sh_r <= 11'h7ff;
          end
          else if (tx_tick)
          begin
            tx_sh_r <= {1'b1, tx_sh_r[10:1]}; // [RULE23] [RULE26]
            tx_cnt_r <= tx_cnt_nxt;
            if ((tx_cnt_nxt == flen) & ~tx_empty)
              tx_extra_r <= 1'b1; // [RULE24]
          end
        end
        default:
          tx_st_r <= TX_IDLE;
      endcase
    end
  end

  // Transmit-side control register.
  always @(posedge clk)
  begin
    if (srst)
    begin
      txcf_r <= `ASP_RST_BYTE;
      txhb_r <= `ASP_RST_BYTE;
    end
    else
    begin
      if (wr_txhb)
        txhb_r <= wd[7:0];
      if (wr_txcf)
        txcf_r <= wd[7:0]; // [RULE11]
      if (tx_st_r == TX_EMPT)
        txcf_r[`ASP_TXCF_EMPTY] <= 1'b1; // [RULE18]
      if (tx_end)
        txcf_r[`ASP_TXCF_RUN] <= tx_again; // [RULE11] [RULE12] [RULE13] [RULE19]
    end
  end

  // Pin drive; output enable is active low.
  always @(posedge clk)
  begin
    if (srst)
    begin
      tx_pin_o <= 1'b1;
      tx_pin_oe_n <= 1'b1;
    end
    else
    begin
      tx_pin_o <= tx_sh_r[0];
      if (~txcf_r[`ASP_TXCF_OE])
        tx_pin_oe_n <= 1'b1; // [RULE15]
      else if (txcf_r[`ASP_TXCF_PP])
        tx_pin_oe_n <= 1'b0; // [RULE16]
      else
        tx_pin_oe_n <= tx_sh_r[0]; // [RULE16]
    end
  end

  assign rx_irq = rxcs_r[`ASP_RXCS_IE] & rxcs_r[`ASP_RXCS_END]; // [RULE10]
  assign tx_irq = txcf_r[`ASP_TXCF_IE] & tx_empty; // [RULE20]
endmodule // asp_top

// ===== verification/asp_chk.sv
// Purpose: Port assertions for asp_top.
// Assumes: One clock, srst synchronous and active high.
// Notes: Bound from the bench top file.
`timescale 1ns/1ps
module asp_chk (
  input wire clk,
  input wire srst,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire tx_pin_o,
  input wire tx_pin_oe_n,
  input wire rx_irq,
  input wire tx_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_reset_idle: assert property ($fell(srst) |-> tx_pin_o && tx_pin_oe_n && !rx_irq && !tx_irq)
    else $error("not idle after reset");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("no write response");
  a_write_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("extra write response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read response");
  a_read_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("extra read response");
  a_read_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_arready)
    else $error("read data or ready wrong");
  a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  a_low_min: assert property ($fell(tx_pin_o) |=> !tx_pin_o [*4] or ##[0:5] s_axi_bvalid)
    else $error("low bit too short");
  a_high_min: assert property ($rose(tx_pin_o) |=> tx_pin_o [*4] or ##[0:5] s_axi_bvalid)
    else $error("high bit too short");
endmodule // asp_chk

// ===== verification/asp_peer.sv
// Purpose: Remote serial node facing asp_top.
// Assumes: Bit period is a whole number of clk cycles.
// Notes: The transmit line has a pull-up, so a released line reads high.
`timescale 1ns/1ps
module asp_peer (
  input wire clk,
  input wire tx_pin_o,
  input wire tx_pin_oe_n,
  output logic rx_pin
);
  wire line = tx_pin_oe_n ? 1'b1 : tx_pin_o;
  initial rx_pin = 1'b1;
  task automatic hold(input logic lv);
    rx_pin <= lv;
  endtask
  // Low start, data from the LSB, then one stop bit at level sb.
  task automatic send(input logic [8:0] d, input int nb, input int per, input logic sb);
    rx_pin <= 1'b0;
    repeat (per) @(posedge clk);
    for (int i = 0; i < nb; i++)
    begin
      rx_pin <= d[i];
      repeat (per) @(posedge clk);
    end
    rx_pin <= sb;
    repeat (per) @(posedge clk);
    rx_pin <= 1'b1;
  endtask
  // Waits for a start bit, then samples each bit at its middle.
  task automatic recv(input int nb, input int per, output logic [8:0] d, output logic ok, output int w);
    d = 9'h0;
    for (w = 0; w < 4000 && line; w++)
      @(posedge clk);
    repeat (per / 2) @(posedge clk);
    ok = !line;
    for (int i = 0; i < nb; i++)
    begin
      repeat (per) @(posedge clk);
      d[i] = line;
    end
    repeat (per) @(posedge clk);
    ok = ok && line;
  endtask
endmodule // asp_peer

// ===== verification/asp_top_tb.sv
// Purpose: Self-checking bench for asp_top.
// Assumes: Baud reload 2 gives bits of 8 or 32 cycles.
// Notes: Register k sits at byte address four times its register index, ASP_IDX_RXCS plus k.
`timescale 1ns/1ps
`include "asp_consts.vh"
module asp_top_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic arv = 1'b0;
  logic [17:0] awa = 18'h0;
  logic [17:0] ara = 18'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] v;
  logic [8:0] got;
  logic ok;
  int w;
  int mismatches = 0;
  int checks = 0;
  wire awr, wrdy, bv, arr, rv, txo, txoe_n, rxp, rxi, txi;
  wire [1:0] br, rr;
  wire [31:0] rdat;
  asp_top u_dut (.clk(clk), .srst(srst), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1), .rx_pin(rxp),
    .tx_pin_o(txo), .tx_pin_oe_n(txoe_n), .rx_irq(rxi), .tx_irq(txi));
  asp_peer u_peer (.clk(clk), .tx_pin_o(txo), .tx_pin_oe_n(txoe_n), .rx_pin(rxp));
  always #5 clk = ~clk;
  // Index 0 to 4: rx control, tx control, baud, tx byte, rx byte; 5 is unmapped.
  function automatic logic [17:0] ad(input int k);
    return {`ASP_IDX_RXCS, 2'b00} + 18'(4 * k);
  endfunction
  task automatic give_verdict;
    if (mismatches == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tmo(input int t);
    if (t >= 999)
    begin
      mismatches++;
      give_verdict();
    end
  endtask
  task automatic wreg(input int k, input logic [7:0] d, input logic [1:0] er = 2'b00);
    int t;
    awa <= ad(k);
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    for (t = 0; t < 999; t++)
    begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      if (bv) break;
    end
    tmo(t);
    chk(br, er);
  endtask
  task automatic rreg(input int k, input logic [1:0] er = 2'b00);
    int t;
    ara <= ad(k);
    arv <= 1'b1;
    for (t = 0; t < 999; t++)
    begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    tmo(t);
    v = rdat;
    chk(rr, er);
  endtask
  task automatic poll(input int k, input int b, input logic lv);
    int t;
    for (t = 0; t < 999; t++)
    begin
      rreg(k);
      if (v[b] === lv) break;
    end
    tmo(t);
  endtask
  task automatic s_regs;
    for (int k = 0; k < 5; k++)
    begin
      rreg(k);
      chk(v, 32'h0);
    end
    rreg(5, 2'b10);
    wreg(5, 8'h11, 2'b10);
    wreg(2, 8'h02);
    wreg(0, 8'h08);
    u_peer.send(9'h0, 8, 8, 1'b1);
    rreg(0);
    chk(v, 32'h08);
    wreg(0, 8'h00);
  endtask
  task automatic s_tx(input logic [7:0] cf, input logic sel, input int nb, input int per, input logic [8:0] e);
    wreg(0, {sel, 7'h0});
    wreg(3, e[7:0]);
    fork
      u_peer.recv(nb, per, got, ok, w);
      begin
        wreg(1, cf);
        @(negedge clk);
        chk(txi, 1'b0);
        @(negedge clk);
        chk(txi, 1'b1);
      end
    join
    chk(ok, 1'b1);
    chk(got, nb == 7 ? {2'b0, e[6:0]} : e);
    poll(1, 7, 1'b0);
    wreg(1, 8'h00);
  endtask
  task automatic s_rx(input logic [7:0] cf, input int nb, input logic [8:0] d, input logic sb);
    wreg(1, cf);
    wreg(0, 8'h41);
    u_peer.send(d, nb, 8, sb);
    poll(0, 1, 1'b1);
    chk(rxi, 1'b1);
    chk(v, {24'h0, 3'b010, !sb, 1'b0, nb == 9 && d[8], 2'b11});
    rreg(4);
    chk(v, nb == 7 ? {25'h0, d[6:0]} : {24'h0, d[7:0]});
    wreg(0, 8'h00);
  endtask
  task automatic s_abort;
    wreg(3, 8'h00);
    wreg(1, 8'hb0);
    repeat (30) @(posedge clk);
    wreg(1, 8'h32);
    @(negedge clk);
    chk(txo, 1'b1);
    @(posedge clk);
    rreg(1);
    chk(v, 32'h32);
    wreg(1, 8'ha0);
    @(negedge clk);
    chk(txoe_n, 1'b1);
    @(negedge clk);
    chk(txoe_n, 1'b0);
    @(posedge clk);
    wreg(1, 8'h80);
    repeat (20) @(posedge clk);
    chk(txoe_n, 1'b1);
    poll(1, 7, 1'b0);
    wreg(1, 8'h00);
    wreg(0, 8'h40);
    fork
      u_peer.send(9'h0, 8, 8, 1'b1);
      begin
        repeat (40) @(posedge clk);
        wreg(0, 8'h00);
      end
    join
    rreg(0);
    chk(v, 32'h12);
    u_peer.hold(1'b0);
    wreg(0, 8'h40);
    rreg(0);
    chk(v[5], 1'b1);
    u_peer.hold(1'b1);
    poll(0, 1, 1'b1);
    wreg(0, 8'h00);
  endtask
  task automatic s_cont;
    wreg(3, 8'h55);
    fork
      begin
        u_peer.recv(8, 8, got, ok, w);
        chk(got, 9'h055);
        u_peer.recv(8, 8, got, ok, w);
      end
      begin
        wreg(1, 8'hb0);
        poll(1, 1, 1'b1);
        wreg(1, 8'hb0);
      end
    join
    chk(got, 9'h055);
    chk(w > 11 && w < 19, 1'b1);
    poll(1, 7, 1'b0);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    s_regs();
    s_tx(8'hf5, 1'b1, 9, 32, 9'h1a5);
    s_tx(8'hb1, 1'b0, 8, 8, 9'h03c);
    s_tx(8'hb9, 1'b0, 7, 8, 9'h0d5);
    s_rx(8'h40, 9, 9'h1c3, 1'b1);
    s_rx(8'h00, 8, 9'h0a6, 1'b0);
    s_rx(8'h08, 7, 9'h0ff, 1'b1);
    s_abort();
    s_cont();
    give_verdict();
  end
endmodule // asp_top_tb
bind asp_top asp_chk u_chk (.clk, .srst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .tx_pin_o, .tx_pin_oe_n, .rx_irq, .tx_irq);
